// ===== dv/vrc_top_tb.sv
// Self-checking testbench for the reference control block
`timescale 1ns/1ps
`default_nettype none
`include "vrc_params.svh"
module vrc_top_tb;
  localparam int unsigned SETTLE = 10;
  logic                   ref_clk;
  logic                   rst;
  logic [`VRC_ADDR_W-1:0] reg_addr;
  logic [7:0]             reg_wdata;
  logic                   reg_wr;
  logic                   reg_rd;
  logic [7:0]             reg_rdata;
  logic                   analog_clk_en;
  vrc_pkg::vrc_ana_ctl_t  ana_ctl;
  logic                   reference_ready;
  int                     fail_count;
  int                     checks_done;
  logic [7:0]             wv [5];
  logic [7:0]             ev [5];

  vrc_top #(.SETTLE_CYC(SETTLE)) u_vrc_top (
    .ref_clk         (ref_clk),
    .rst             (rst),
    .reg_addr        (reg_addr),
    .reg_wdata       (reg_wdata),
    .reg_wr          (reg_wr),
    .reg_rd          (reg_rd),
    .reg_rdata       (reg_rdata),
    .analog_clk_en   (analog_clk_en),
    .ana_ctl         (ana_ctl),
    .reference_ready (reference_ready)
  );

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  task automatic complete_run();
    if (fail_count == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    checks_done++;
    if (s !== e) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  // Outputs are sampled 1 ns after the edge that takes the strobe
  task automatic wr(input logic [19:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr    <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [19:0] a, input logic [7:0] e, input string n);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd   <= 1'b0;
    #1;
    chk(n, e, reg_rdata);
  endtask : rd

  initial begin
    int n;
    fail_count = 0;
    checks_done = 0;
    rst = 1'b1;
    reg_addr = '0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    wv = '{8'h00, 8'h02, 8'h08, 8'h0a, 8'h0b};
    ev = '{8'h08, 8'h0e, 8'h50, 8'h54, 8'h66};
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    rd(`VRC_OFS_CLK_GATE, 8'h00, "clk_gate_reset");
    rd(`VRC_OFS_REF_CTRL, 8'h00, "ref_ctrl_reset");
    chk("clk_en_reset", 8'h00, {7'h00, analog_clk_en});
    chk("ana_ctl_reset", 8'h08, ana_ctl);
    // Writes while the analog clock is stopped must not stick
    wr(`VRC_OFS_REF_CTRL, 8'h8b);
    rd(`VRC_OFS_REF_CTRL, 8'h00, "ref_ctrl_gated");
    wr(`VRC_OFS_CLK_GATE, 8'hff);
    rd(`VRC_OFS_CLK_GATE, 8'hff, "clk_gate_byte");
    wr(`VRC_OFS_CLK_GATE, 8'h20);
    chk("clk_en_on", 8'h01, {7'h00, analog_clk_en});
    rd(`VRC_OFS_CLK_GATE, 8'h20, "clk_gate_rd");
    @(posedge ref_clk);
    #1;
    chk("rdata_after", 8'h00, reg_rdata);
    // Start order: level, then source, then source with level, then on
    for (int i = 0; i < 5; i++) begin
      wr(`VRC_OFS_REF_CTRL, wv[i]);
      chk("ana_ctl", ev[i], ana_ctl);
      rd(`VRC_OFS_REF_CTRL, wv[i], "ref_ctrl_rd");
    end
    repeat (4) @(posedge ref_clk);
    #1;
    chk("ready_early", 8'h00, {7'h00, reference_ready});
    n = 0;
    while (reference_ready !== 1'b1 && n < 40) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    if (n >= 40) begin
      fail_count++;
      complete_run();
    end
    rd(`VRC_OFS_STATUS, 8'h04, "settle_state");
    wr(`VRC_OFS_REF_CTRL, 8'hff);
    rd(`VRC_OFS_REF_CTRL, 8'h8b, "fixed_zero");
    chk("ana_ctl_neg", 8'he6, ana_ctl);
    // Single-bit ops: clear bit 7, then try to set a fixed-zero bit
    wr(`VRC_OFS_BITSET, 8'h47);
    rd(`VRC_OFS_REF_CTRL, 8'h0b, "bit_clear");
    wr(`VRC_OFS_BITSET, 8'hc6);
    rd(`VRC_OFS_REF_CTRL, 8'h0b, "bit_fixed");
    rd(20'h12345, 8'h00, "unmapped");
    wr(`VRC_OFS_REF_CTRL, 8'h0a);
    wr(`VRC_OFS_REF_CTRL, 8'h01);
    chk("prohibited", 8'h01, {7'h00, ana_ctl.prohibited});
    chk("ready_off", 8'h00, {7'h00, reference_ready});
    // Dropping the enable puts the reference back in its reset state
    wr(`VRC_OFS_REF_CTRL, 8'h08);
    wr(`VRC_OFS_BITSET, 8'h05);
    chk("clk_en_off", 8'h00, {7'h00, analog_clk_en});
    chk("ana_ctl_off", 8'h08, ana_ctl);
    wr(`VRC_OFS_REF_CTRL, 8'h08);
    rd(`VRC_OFS_REF_CTRL, 8'h00, "ref_ctrl_off");
    wr(`VRC_OFS_CLK_GATE, 8'h20);
    @(posedge ref_clk);
    rst <= 1'b1;
    @(posedge ref_clk);
    rst <= 1'b0;
    rd(`VRC_OFS_CLK_GATE, 8'h00, "clk_gate_rerst");
    chk("ana_ctl_rerst", 8'h08, ana_ctl);
    complete_run();
  end
endmodule : vrc_top_tb
`default_nettype wire

// ===== src/vrc_params.svh
// Register map, field positions, reset values and timing constants of the reference control block
`ifndef VRC_PARAMS_SVH
`define VRC_PARAMS_SVH

`define VRC_ADDR_W          20
`define VRC_OFS_CLK_GATE    20'hf00f0
`define VRC_OFS_REF_CTRL    20'hfff36
`define VRC_OFS_STATUS      20'hfff38
`define VRC_OFS_BITSET      20'hfff3a
`define VRC_RST_CLK_GATE    8'h00
`define VRC_RST_REF_CTRL    8'h00
`define VRC_BIT_ANA_EN      5
`define VRC_BIT_NEG_SEL     7
`define VRC_BIT_SRC_SEL     3
`define VRC_BIT_LEVEL       1
`define VRC_BIT_ON          0
`define VRC_BITOP_VAL       7
`define VRC_BITOP_TGT       6
`define VRC_BITOP_IDX_W     3
`define VRC_REF_CTRL_MASK   8'h8b
`define VRC_SETTLE_MS       17
`define VRC_CLK_HZ          40000000
`define VRC_SETTLE_CYC      (`VRC_SETTLE_MS * (`VRC_CLK_HZ / 1000))

`endif

// ===== src/vrc_pkg.sv
// Types shared by the reference control block
`default_nettype none
package vrc_pkg;
  typedef struct packed {
    logic       neg_ext;
    logic       pos_internal;
    logic       ref_enable;
    logic       ref_pulldown;
    logic       ref_hiz;
    logic       level_2v0;
    logic       boost_enable;
    logic       prohibited;
  } vrc_ana_ctl_t;

  typedef enum logic [2:0] {
    VRC_OFF    = 3'b001,
    VRC_SETTLE = 3'b010,
    VRC_READY  = 3'b100
  } vrc_state_t;
endpackage : vrc_pkg
`default_nettype wire

// ===== src/vrc_settle.sv
// Settling timer that reports when the reference has had its full start-up time
`timescale 1ns/1ps
`default_nettype none
`include "vrc_params.svh"
module vrc_settle #(
  parameter int unsigned SETTLE_CYC = `VRC_SETTLE_CYC
) (
  // Clock and reset
  input  wire logic              ref_clk,
  input  wire logic              rst,
  // Control
  input  wire logic              run,
  // Status
  output logic                   settled,
  output vrc_pkg::vrc_state_t    state
);
  localparam int CW = $clog2(SETTLE_CYC + 1);

  vrc_pkg::vrc_state_t state_r;
  vrc_pkg::vrc_state_t state_nxt;
  logic [CW-1:0]       cnt_r;
  logic [CW-1:0]       cnt_nxt;

  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    unique case (state_r)
      vrc_pkg::VRC_OFF: begin
        cnt_nxt = '0;
        if (run) begin
          state_nxt = vrc_pkg::VRC_SETTLE;
        end
      end
      vrc_pkg::VRC_SETTLE: begin
        cnt_nxt = cnt_r + 1'b1;
        if (!run) begin
          state_nxt = vrc_pkg::VRC_OFF;
        end else if (cnt_r == CW'(SETTLE_CYC - 1)) begin
          state_nxt = vrc_pkg::VRC_READY;
        end
      end
      vrc_pkg::VRC_READY: begin
        if (!run) begin
          state_nxt = vrc_pkg::VRC_OFF;
        end
      end
      default: begin
        state_nxt = vrc_pkg::VRC_OFF;
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_r <= vrc_pkg::VRC_OFF;
      cnt_r   <= '0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
    end
  end

  assign settled = (state_r == vrc_pkg::VRC_READY);
  assign state   = state_r;
endmodule : vrc_settle
`default_nettype wire

// ===== src/vrc_top.sv
// Voltage reference control: clock gate, reference control register and analog control outputs
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "vrc_params.svh"
module vrc_top #(
  parameter int unsigned SETTLE_CYC = `VRC_SETTLE_CYC
) (
  // Clock and reset
  input  wire logic                   ref_clk,
  input  wire logic                   rst,
  // Register port
  input  wire logic [`VRC_ADDR_W-1:0] reg_addr,
  input  wire logic [7:0]             reg_wdata,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  output logic      [7:0]             reg_rdata,
  // Analog group
  output logic                        analog_clk_en,
  output vrc_pkg::vrc_ana_ctl_t       ana_ctl,
  output logic                        reference_ready
);
  // Clock-gate register bits other than the analog enable are kept as plain storage
  logic [7:0]            clk_gate_r;
  logic [7:0]            clk_gate_nxt;
  logic [7:0]            ref_ctrl_r;
  logic [7:0]            ref_ctrl_nxt;
  logic [7:0]            rdata_r;
  logic [7:0]            rdata_nxt;
  logic                  clk_en_r;
  vrc_pkg::vrc_ana_ctl_t ana_r;
  vrc_pkg::vrc_ana_ctl_t ana_nxt;
  logic                  ready_r;
  logic                  settled;
  vrc_pkg::vrc_state_t   settle_state;
  logic                  ana_en;
  logic                  ready_nxt;

  // Single-bit write: wdata[7] is the value, wdata[2:0] the bit number
  function automatic logic [7:0] bit_write(input logic [7:0] cur, input logic [7:0] wd);
    logic [7:0] res;
    res = cur;
    res[wd[`VRC_BITOP_IDX_W-1:0]] = wd[`VRC_BITOP_VAL];
    return res;
  endfunction : bit_write

  // Decode of the reference control field set into analog controls
  function automatic vrc_pkg::vrc_ana_ctl_t decode_ref(input logic [7:0] rc);
    vrc_pkg::vrc_ana_ctl_t a;
    logic src;
    logic lvl;
    logic on;
    src = rc[`VRC_BIT_SRC_SEL];
    lvl = rc[`VRC_BIT_LEVEL];
    on  = rc[`VRC_BIT_ON];
    a.neg_ext      = rc[`VRC_BIT_NEG_SEL];
    a.pos_internal = src;
    a.ref_enable   = src & on;
    a.ref_pulldown = src & ~on;
    a.ref_hiz      = ~src;
    a.level_2v0    = lvl;
    // Boost runs for external source at level 1 with the on bit clear, or whenever the internal reference is on
    a.boost_enable = src ? on : lvl;
    // Source 0 with the on bit set is not a legal combination
    a.prohibited   = ~src & on;
    if (a.prohibited) begin
      a.ref_enable   = 1'b0;
      a.boost_enable = 1'b0;
    end
    return a;
  endfunction : decode_ref

  // Analog controls reset to the decode of the reset register value, so the
  // reference reads as stopped and Hi-Z even while reset is still held
  localparam vrc_pkg::vrc_ana_ctl_t ANA_RST  = decode_ref(`VRC_RST_REF_CTRL);
  localparam logic [7:0]            REF_MASK = `VRC_REF_CTRL_MASK;
  localparam int                    CYC_W    = $clog2(SETTLE_CYC + 3);

  assign ana_en = clk_gate_r[`VRC_BIT_ANA_EN];

  // Register writes
  always_comb begin
    clk_gate_nxt = clk_gate_r;
    ref_ctrl_nxt = ref_ctrl_r;
    if (reg_wr) begin
      unique case (reg_addr)
        `VRC_OFS_CLK_GATE: clk_gate_nxt = reg_wdata;
        `VRC_OFS_REF_CTRL: begin
          if (ana_en) begin
            ref_ctrl_nxt = reg_wdata & `VRC_REF_CTRL_MASK;
          end
        end
        `VRC_OFS_BITSET: begin
          if (reg_wdata[`VRC_BITOP_TGT]) begin
            if (ana_en) begin
              ref_ctrl_nxt = bit_write(ref_ctrl_r, reg_wdata) & `VRC_REF_CTRL_MASK;
            end
          end else begin
            clk_gate_nxt = bit_write(clk_gate_r, reg_wdata);
          end
        end
        default: ;
      endcase
    end
    // Clearing the enable puts the analog group back in its reset state
    if (!clk_gate_nxt[`VRC_BIT_ANA_EN]) begin
      ref_ctrl_nxt = `VRC_RST_REF_CTRL;
    end
  end

  // Register reads, one cycle later
  always_comb begin
    rdata_nxt = 8'h00;
    if (reg_rd) begin
      unique case (reg_addr)
        `VRC_OFS_CLK_GATE: rdata_nxt = clk_gate_r;
        `VRC_OFS_REF_CTRL: rdata_nxt = ana_en ? ref_ctrl_r : `VRC_RST_REF_CTRL;
        `VRC_OFS_STATUS:   rdata_nxt = {5'h00, settle_state};
        default:           rdata_nxt = 8'h00;
      endcase
    end
  end

  always_comb begin
    ana_nxt   = decode_ref(ref_ctrl_nxt);
    // Ready falls as soon as the reference stops, not when the timer catches up
    ready_nxt = settled & ana_r.ref_enable;
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      clk_gate_r <= `VRC_RST_CLK_GATE;
      ref_ctrl_r <= `VRC_RST_REF_CTRL;
      rdata_r    <= 8'h00;
      clk_en_r   <= 1'b0;
      ana_r      <= ANA_RST;
      ready_r    <= 1'b0;
    end else begin
      clk_gate_r <= clk_gate_nxt;
      ref_ctrl_r <= ref_ctrl_nxt;
      rdata_r    <= rdata_nxt;
      clk_en_r   <= clk_gate_nxt[`VRC_BIT_ANA_EN];
      ana_r      <= ana_nxt;
      ready_r    <= ready_nxt;
    end
  end

  // The timer only watches the on state; it does not hold back the reference itself
  vrc_settle #(
    .SETTLE_CYC (SETTLE_CYC)
  ) u_settle (
    .ref_clk (ref_clk),
    .rst     (rst),
    .run     (ana_r.ref_enable),
    .settled (settled),
    .state   (settle_state)
  );

  assign reg_rdata       = rdata_r;
  assign analog_clk_en   = clk_en_r;
  assign ana_ctl         = ana_r;
  assign reference_ready = ready_r;

  // Bus events and an on-time counter used only by the checks below
  logic             wr_gate_byte;
  logic             wr_ref_byte;
  logic             wr_gate_bit;
  logic             wr_ref_bit;
  logic             wr_unmapped;
  logic             rd_ref;
  logic             rd_gate;
  logic [CYC_W-1:0] on_cyc_r;
  logic [CYC_W-1:0] on_cyc_nxt;

  assign wr_gate_byte = reg_wr && (reg_addr == `VRC_OFS_CLK_GATE);
  assign wr_ref_byte  = reg_wr && (reg_addr == `VRC_OFS_REF_CTRL);
  assign wr_gate_bit  = reg_wr && (reg_addr == `VRC_OFS_BITSET) && !reg_wdata[`VRC_BITOP_TGT];
  assign wr_ref_bit   = reg_wr && (reg_addr == `VRC_OFS_BITSET) && reg_wdata[`VRC_BITOP_TGT];
  assign wr_unmapped  = reg_wr && !(reg_addr inside {`VRC_OFS_CLK_GATE, `VRC_OFS_REF_CTRL, `VRC_OFS_BITSET});
  assign rd_ref       = reg_rd && (reg_addr == `VRC_OFS_REF_CTRL);
  assign rd_gate      = reg_rd && (reg_addr == `VRC_OFS_CLK_GATE);

  // Saturates, so a long on period cannot wrap and look unsettled again
  always_comb begin
    on_cyc_nxt = '0;
    if (ana_r.ref_enable) begin
      on_cyc_nxt = (on_cyc_r == CYC_W'(SETTLE_CYC + 2)) ? on_cyc_r : on_cyc_r + 1'b1;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      on_cyc_r <= '0;
    end else begin
      on_cyc_r <= on_cyc_nxt;
    end
  end

  AST_WR_BLOCKED: assert property (@(posedge ref_clk) disable iff (rst)
    (reg_wr && reg_addr == `VRC_OFS_REF_CTRL && !ana_en) |=> ref_ctrl_r == $past(ref_ctrl_r))
    else $error("reference control changed while analog clock off");
  AST_RD_DEFAULT: assert property (@(posedge ref_clk) disable iff (rst)
    (reg_rd && reg_addr == `VRC_OFS_REF_CTRL && !ana_en) |=> reg_rdata == `VRC_RST_REF_CTRL)
    else $error("reference control read not default while disabled");
  AST_CLK_GATE: assert property (@(posedge ref_clk) disable iff (rst)
    analog_clk_en == clk_gate_r[`VRC_BIT_ANA_EN])
    else $error("analog clock enable disagrees with register bit");
  AST_ZERO_BITS: assert property (@(posedge ref_clk) disable iff (rst)
    (ref_ctrl_r & ~`VRC_REF_CTRL_MASK) == 8'h00)
    else $error("fixed-zero bits of reference control set");
  AST_NEG_SEL: assert property (@(posedge ref_clk) disable iff (rst)
    ana_ctl.neg_ext == ref_ctrl_r[`VRC_BIT_NEG_SEL])
    else $error("negative reference select mismatch");
  AST_HIZ: assert property (@(posedge ref_clk) disable iff (rst)
    !ref_ctrl_r[`VRC_BIT_SRC_SEL] |-> (ana_ctl.ref_hiz && !ana_ctl.ref_enable && !ana_ctl.pos_internal))
    else $error("external source selected but reference not stopped at Hi-Z");
  AST_INT_ON: assert property (@(posedge ref_clk) disable iff (rst)
    (ref_ctrl_r[`VRC_BIT_SRC_SEL] && ref_ctrl_r[`VRC_BIT_ON]) |->
      (ana_ctl.ref_enable && ana_ctl.boost_enable && ana_ctl.level_2v0 == ref_ctrl_r[`VRC_BIT_LEVEL]))
    else $error("internal reference on but outputs wrong");
  AST_PULLDOWN: assert property (@(posedge ref_clk) disable iff (rst)
    (ref_ctrl_r[`VRC_BIT_SRC_SEL] && !ref_ctrl_r[`VRC_BIT_ON]) |-> ana_ctl.ref_pulldown)
    else $error("internal reference off but not pulled down");
  AST_BYTE_WR: assert property (@(posedge ref_clk) disable iff (rst)
    (reg_wr && reg_addr == `VRC_OFS_CLK_GATE) |=> clk_gate_r == $past(reg_wdata))
    else $error("clock-gate byte write not stored");
  AST_READY_OFF: assert property (@(posedge ref_clk) disable iff (rst)
    (ana_ctl.ref_enable && !$past(ana_ctl.ref_enable)) |=> !reference_ready [*2])
    else $error("reference reported ready without settling");

  // Clock gate and register access
  AST_GATE_OFF_RESET: assert property (@(posedge ref_clk) disable iff (rst)
    !clk_gate_r[`VRC_BIT_ANA_EN] |-> (ref_ctrl_r == `VRC_RST_REF_CTRL && ana_ctl == ANA_RST))
    else $error("analog group not held in reset state while clock off");
  AST_EN_BYTE_SET: assert property (@(posedge ref_clk) disable iff (rst)
    (wr_gate_byte && reg_wdata[`VRC_BIT_ANA_EN]) |=> analog_clk_en)
    else $error("byte write did not start analog clock");
  AST_EN_BYTE_CLR: assert property (@(posedge ref_clk) disable iff (rst)
    (wr_gate_byte && !reg_wdata[`VRC_BIT_ANA_EN]) |=> (!analog_clk_en && ana_ctl == ANA_RST))
    else $error("byte write did not stop analog clock");
  AST_EN_BIT_SET: assert property (@(posedge ref_clk) disable iff (rst)
    (wr_gate_bit && reg_wdata[`VRC_BITOP_IDX_W-1:0] == 3'(`VRC_BIT_ANA_EN) && reg_wdata[`VRC_BITOP_VAL]) |=>
      analog_clk_en)
    else $error("single-bit write did not start analog clock");
  AST_EN_BIT_CLR: assert property (@(posedge ref_clk) disable iff (rst)
    (wr_gate_bit && reg_wdata[`VRC_BITOP_IDX_W-1:0] == 3'(`VRC_BIT_ANA_EN) && !reg_wdata[`VRC_BITOP_VAL]) |=>
      (!analog_clk_en && ana_ctl == ANA_RST))
    else $error("single-bit write did not stop analog clock");
  AST_BIT_WR_BLOCKED: assert property (@(posedge ref_clk) disable iff (rst)
    (wr_ref_bit && !ana_en) |=> $stable(ref_ctrl_r))
    else $error("single-bit write landed while analog clock off");
  AST_RD_LIVE: assert property (@(posedge ref_clk) disable iff (rst)
    (rd_ref && ana_en) |=> reg_rdata == $past(ref_ctrl_r))
    else $error("reference control read wrong while enabled");
  AST_RD_GATE: assert property (@(posedge ref_clk) disable iff (rst)
    rd_gate |=> reg_rdata == $past(clk_gate_r))
    else $error("clock-gate read wrong");
  AST_REF_BYTE_WR: assert property (@(posedge ref_clk) disable iff (rst)
    (wr_ref_byte && ana_en) |=> ref_ctrl_r == ($past(reg_wdata) & REF_MASK))
    else $error("reference control byte write not stored");
  AST_UNMAPPED_WR: assert property (@(posedge ref_clk) disable iff (rst)
    wr_unmapped |=> ($stable(clk_gate_r) && $stable(ref_ctrl_r)))
    else $error("unmapped write changed a register");

  // Decode of the reference control register
  AST_SRC_FIELD: assert property (@(posedge ref_clk) disable iff (rst)
    ana_ctl.pos_internal == ref_ctrl_r[`VRC_BIT_SRC_SEL] && ana_ctl.level_2v0 == ref_ctrl_r[`VRC_BIT_LEVEL])
    else $error("source or level field mismatch");
  AST_BOOST_EXT: assert property (@(posedge ref_clk) disable iff (rst)
    !ref_ctrl_r[`VRC_BIT_SRC_SEL] |->
      ana_ctl.boost_enable == (ref_ctrl_r[`VRC_BIT_LEVEL] && !ref_ctrl_r[`VRC_BIT_ON]))
    else $error("boost does not follow level with external source");
  AST_INT_OFF: assert property (@(posedge ref_clk) disable iff (rst)
    (ref_ctrl_r[`VRC_BIT_SRC_SEL] && !ref_ctrl_r[`VRC_BIT_ON]) |->
      (!ana_ctl.ref_enable && !ana_ctl.boost_enable && !ana_ctl.ref_hiz))
    else $error("internal reference off but still running");
  AST_PROHIBITED: assert property (@(posedge ref_clk) disable iff (rst)
    (!ref_ctrl_r[`VRC_BIT_SRC_SEL] && ref_ctrl_r[`VRC_BIT_ON]) |->
      (ana_ctl.prohibited && !ana_ctl.ref_enable && !ana_ctl.boost_enable))
    else $error("prohibited setting not flagged and blocked");
  AST_LEGAL: assert property (@(posedge ref_clk) disable iff (rst)
    (ref_ctrl_r[`VRC_BIT_SRC_SEL] || !ref_ctrl_r[`VRC_BIT_ON]) |-> !ana_ctl.prohibited)
    else $error("legal setting flagged as prohibited");
  // The output is always in exactly one of running, pulled down or Hi-Z
  AST_ONE_STATE: assert property (@(posedge ref_clk) disable iff (rst)
    $onehot({ana_ctl.ref_enable, ana_ctl.ref_pulldown, ana_ctl.ref_hiz}))
    else $error("reference output state not unique");

  // Settling report
  AST_READY_DROP: assert property (@(posedge ref_clk) disable iff (rst)
    !ana_ctl.ref_enable |=> !reference_ready)
    else $error("ready still reported after reference stopped");
  AST_READY_EARLY: assert property (@(posedge ref_clk) disable iff (rst)
    reference_ready |-> on_cyc_r >= CYC_W'(SETTLE_CYC + 2))
    else $error("ready reported before settling time elapsed");
  AST_READY_DUE: assert property (@(posedge ref_clk) disable iff (rst)
    on_cyc_r == CYC_W'(SETTLE_CYC + 2) |-> reference_ready)
    else $error("ready not reported after settling time");

  // One check per bit of the single-bit path; fixed-zero bits must stay clear
  for (genvar gi = 0; gi < $bits(ref_ctrl_r); gi++) begin : g_bitop_chk
    AST_BITOP_REF: assert property (@(posedge ref_clk) disable iff (rst)
      (wr_ref_bit && ana_en && reg_wdata[`VRC_BITOP_IDX_W-1:0] == 3'(gi)) |=>
        ref_ctrl_r[gi] == (REF_MASK[gi] && $past(reg_wdata[`VRC_BITOP_VAL])))
      else $error("single-bit write to reference control not applied");
  end
endmodule : vrc_top
`default_nettype wire
